// file: rtl/asec_reg_error_check.sv
`timescale 1ns/1ps
module asec_reg_error_check import asec_pkg::*; (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            nrst,
  // AXI4-Lite write address and data
  input  wire logic [AW-1:0]   s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0]   s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [DW-1:0]        s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // Translation side events from the pipeline
  input  wire logic            itlbUpdate,
  input  wire logic            dtlbUpdate,
  input  wire logic            tlbLookup,
  input  wire logic            tagWrite,
  input  wire logic [DW-1:0]   tagVa,
  input  wire logic            tagVaPar,
  // Interrupt packets from the interconnect
  input  wire logic            pktValid,
  input  asec_code_t           pkt,
  output logic                 pktReady,
  // Barrier variable link
  input  wire logic            bvValid,
  input  asec_code_t           bv,
  // Traps and interrupt
  output logic                 vecTrap,
  output logic                 irq
);
  // Register state
  logic [2:0]     ctrl_reg;        // Error control bits
  logic [NST-1:0] status_reg;      // Sticky error types
  logic [NST-1:0] mask_reg;        // Interrupt mask
  logic [7:0]     inject_reg;      // Check code and parity flip pattern
  logic [DW-1:0]  parData_reg [4]; // Always, aug, enable, tag va
  logic           parBit_reg  [4]; // Their parity bits
  asec_code_t     ecc_reg     [3]; // Check-coded, instr src, data src
  asec_code_t     rx_reg;          // Received interrupt word
  logic           busy_reg;        // Receive busy flag
  logic           lock_reg;        // Held off after a bad packet
  logic           vecTrap_reg;     // Trap pulse
  logic           iPoison_reg;     // Propagated error, instr pointers
  logic           dPoison_reg;     // Propagated error, data pointers
  // Bus state
  asec_wr_t       wrState_reg;
  logic           awHeld_reg;
  logic           wHeld_reg;
  logic [AW-1:0]  awAddr_reg;
  logic [DW-1:0]  wData_reg;
  logic [3:0]     wStrb_reg;
  logic [1:0]     bresp_reg;
  logic           rvalid_reg;
  logic [DW-1:0]  rdata_reg;
  logic [1:0]     rresp_reg;
  // Checker results
  asec_code_t     decIn    [7];
  logic [CW-1:0]  decGen   [7];
  logic [DW-1:0]  decFix   [7];
  logic           decCe    [7];
  logic           decUe    [7];
  logic           parGen   [4];
  logic           parBad   [4];
  // Glue
  logic           commit;          // Write applied this cycle
  logic           rdTake;          // Load taken this cycle
  logic           pktTake;         // Packet accepted this cycle
  logic           augPeriod;       // Autonomous checking active
  logic [32:0]    wrOld;
  logic [DW-1:0]  wrMerged;
  logic [32:0]    rdVal;
  logic [NST-1:0] evt;
  logic [NST-1:0] clr;
  logic [DW-1:0]  ptrIp8, ptrIp64, ptrDp8, ptrDp64, ptrDd;

  // Checker inputs: stored words, packet, link, write encoder
  always_comb begin
    decIn[0] = ecc_reg[0];
    decIn[1] = ecc_reg[1];
    decIn[2] = ecc_reg[2];
    decIn[3] = rx_reg;
    decIn[4] = pkt;
    decIn[5] = bv;
    decIn[6] = '{data: wrMerged, check: '0};
  end

  // One decoder per coded word
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : gDec
      asec_secded uDec (
        .word      (decIn[g]),
        .genCheck  (decGen[g]),
        .fixedData (decFix[g]),
        .corrErr   (decCe[g]),
        .uncorrErr (decUe[g])
      );
    end
    for (g = 0; g < 4; g++) begin : gPar
      asec_parity uPar (
        .data (parData_reg[g]),
        .par  (parBit_reg[g]),
        .gen  (parGen[g]),
        .bad  (parBad[g])
      );
    end
  endgenerate

  // Pointers built from a source and the latched tag address
  assign ptrIp8  = {decFix[1][DW-1:BASE_LSB], parData_reg[3][PG8_LSB+7:PG8_LSB], PTR_LOW8};
  assign ptrIp64 = {decFix[1][DW-1:BASE_LSB], parData_reg[3][PG64_LSB+7:PG64_LSB], PTR_LOW8};
  assign ptrDp8  = {decFix[2][DW-1:BASE_LSB], parData_reg[3][PG8_LSB+7:PG8_LSB], PTR_LOW8};
  assign ptrDp64 = {decFix[2][DW-1:BASE_LSB], parData_reg[3][PG64_LSB+7:PG64_LSB], PTR_LOW8};
  assign ptrDd   = {decFix[2][DW-1:BASE_LSB], parData_reg[3][DIR_LSB+7:DIR_LSB], PTR_LOWD};

  // Register view: {hit, value}; coded words read back corrected
  function automatic logic [32:0] readVal(input logic [AW-1:0] a);
    logic [DW-1:0] v;
    logic          hit;
    v   = '0;
    hit = 1'b1;
    case ({a[AW-1:2], 2'b00})
      A_CTRL:   v = 32'(ctrl_reg);
      A_STATUS: v = 32'(status_reg);
      A_MASK:   v = 32'(mask_reg);
      A_INJECT: v = 32'(inject_reg);
      A_ALWAYS: v = parData_reg[0];
      A_AUG:    v = parData_reg[1];
      A_ENREG:  v = parData_reg[2];
      A_ECCREG: v = decFix[0];
      A_ISRC:   v = decFix[1];
      A_DSRC:   v = decFix[2];
      A_IPTR8:  v = ptrIp8;
      A_IPTR64: v = ptrIp64;
      A_DPTR8:  v = ptrDp8;
      A_DPTR64: v = ptrDp64;
      A_DPTRD:  v = ptrDd;
      A_RXDATA: v = decFix[3];
      A_RXBUSY: v = 32'(busy_reg);
      default:  hit = 1'b0;
    endcase
    return {hit, v};
  endfunction : readVal

  // Byte lanes merge into the current value before encoding
  always_comb begin
    wrOld = readVal(awAddr_reg);
    for (int b = 0; b < 4; b++) begin
      wrMerged[b*8 +: 8] = wStrb_reg[b] ? wData_reg[b*8 +: 8] : wrOld[b*8 +: 8];
    end
  end

  // A process, not an assign: the view reads state beyond its argument,
  // so a plain assign would go stale while the address stands still
  always_comb rdVal = readVal(s_axi_araddr);
  assign commit    = wrState_reg == WS_COLLECT && awHeld_reg && wHeld_reg;
  assign rdTake    = s_axi_arvalid && s_axi_arready;
  assign augPeriod = !ctrl_reg[C_UGH] && !ctrl_reg[C_WEAK];
  assign pktReady  = !busy_reg && !lock_reg;
  assign pktTake   = pktValid && pktReady;

  // Write channels: address and data land in either order
  assign s_axi_awready = wrState_reg == WS_COLLECT && !awHeld_reg;
  assign s_axi_wready  = wrState_reg == WS_COLLECT && !wHeld_reg;
  assign s_axi_bvalid  = wrState_reg == WS_RESP;
  assign s_axi_bresp   = bresp_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrState_reg <= WS_COLLECT;
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awAddr_reg  <= '0;
      wData_reg   <= '0;
      wStrb_reg   <= '0;
      bresp_reg   <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      unique case (wrState_reg)
        WS_COLLECT: begin
          if (commit) begin
            awHeld_reg  <= 1'b0;
            wHeld_reg   <= 1'b0;
            bresp_reg   <= wrOld[32] ? RESP_OK : RESP_ERR;
            wrState_reg <= WS_RESP;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) wrState_reg <= WS_COLLECT;
        end
      endcase
    end
  end

  // Read channel: one load at a time, answered next cycle
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OK;
    end else if (rdTake) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdVal[31:0];
      // Unmapped reads return zero with an error
      rresp_reg  <= rdVal[32] ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control, mask and inject registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg   <= RST_CTRL;
      mask_reg   <= RST_MASK;
      inject_reg <= '0;
    end else if (commit) begin
      if (awAddr_reg[AW-1:2] == A_CTRL[AW-1:2]) ctrl_reg <= wrMerged[2:0];
      if (awAddr_reg[AW-1:2] == A_MASK[AW-1:2]) mask_reg <= wrMerged[NST-1:0];
      if (awAddr_reg[AW-1:2] == A_INJECT[AW-1:2]) inject_reg <= wrMerged[7:0];
    end
  end

  // Parity words; a full rewrite restores good parity
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        parData_reg[i] <= '0;
        parBit_reg[i]  <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (commit && awAddr_reg[AW-1:2] == A_ALWAYS[AW-1:2] + 6'(i)) begin
          parData_reg[i] <= wrMerged;
          parBit_reg[i]  <= (^wrMerged) ^ inject_reg[I_PAR];
        end
      end
      // Tag address arrives with parity from the pipeline
      if (tagWrite) begin
        parData_reg[3] <= tagVa;
        parBit_reg[3]  <= tagVaPar;
      end
    end
  end

  // Coded words store fresh code xor inject pattern
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) ecc_reg[i] <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (commit && awAddr_reg[AW-1:2] == A_ECCREG[AW-1:2] + 6'(i)) begin
          ecc_reg[i] <= '{data: wrMerged, check: decGen[6] ^ inject_reg[CW-1:0]};
        end
      end
    end
  end

  // Pointer error propagation from sources and the tag parity
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      iPoison_reg <= 1'b0;
      dPoison_reg <= 1'b0;
    end else begin
      iPoison_reg <= decUe[1] || parBad[3];
      dPoison_reg <= decUe[2] || parBad[3];
    end
  end

  // Interrupt receive: check on arrival, lock on bad packet
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_reg      <= '0;
      busy_reg    <= 1'b0;
      lock_reg    <= 1'b0;
      vecTrap_reg <= 1'b0;
    end else begin
      vecTrap_reg <= pktTake;
      if (commit && awAddr_reg[AW-1:2] == A_RXBUSY[AW-1:2] && !wrMerged[0]) begin
        busy_reg <= 1'b0;
        lock_reg <= 1'b0;
      end
      if (pktTake) begin
        if (decUe[4]) begin
          lock_reg <= 1'b1;
        end else begin
          rx_reg   <= pkt;
          busy_reg <= 1'b1;
        end
      end
    end
  end
  assign vecTrap = vecTrap_reg;

  // Error events by detect condition
  always_comb begin
    evt           = '0;
    evt[S_ALWAYS] = parBad[0];
    evt[S_AUG]    = augPeriod && parBad[1];
    evt[S_BV]     = augPeriod && bvValid && decUe[5];
    evt[S_ENAB]   = ctrl_reg[C_EN] && parBad[2];
    evt[S_ITLB]   = itlbUpdate && decUe[1];
    evt[S_DTLB]   = dtlbUpdate && decUe[2];
    evt[S_TLBUSE] = tlbLookup && (decUe[1] || decUe[2]);
    evt[S_INTR]   = pktTake && decUe[4];
    if (rdTake) begin
      // Load-class words checked only as they are read
      unique case ({s_axi_araddr[AW-1:2], 2'b00})
        A_ECCREG: evt[S_LOAD] = decUe[0];
        A_ISRC:   evt[S_LOAD] = decUe[1];
        A_DSRC:   evt[S_LOAD] = decUe[2];
        A_RXDATA: evt[S_LOAD] = decUe[3];
        A_IPTR8, A_IPTR64: evt[S_PTR] = iPoison_reg;
        A_DPTR8, A_DPTR64, A_DPTRD: evt[S_PTR] = dPoison_reg;
        default: evt[S_LOAD] = 1'b0;
      endcase
      case ({s_axi_araddr[AW-1:2], 2'b00})
        A_ECCREG: evt[S_CE] = decCe[0];
        A_ISRC:   evt[S_CE] = decCe[1];
        A_DSRC:   evt[S_CE] = decCe[2];
        A_RXDATA: evt[S_CE] = decCe[3];
        default:  evt[S_CE] = 1'b0;
      endcase
    end
  end

  // Status: write one to clear; a new event wins over the clear
  assign clr = (commit && awAddr_reg[AW-1:2] == A_STATUS[AW-1:2]) ? wrMerged[NST-1:0] : '0;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clr) | evt;
    end
  end

  // Level interrupt while any unmasked type is set
  assign irq = |(status_reg & mask_reg);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_badPkt;
    pktTake && decUe[4];
  endsequence
  sequence s_trapNoBusy;
    vecTrap && !busy_reg && !pktReady;
  endsequence

  a_always_flag: assert property (parBad[0] |=> status_reg[S_ALWAYS])
    else $error("always-class fault not flagged");
  a_aug_gated: assert property (!augPeriod |=> !$rose(status_reg[S_AUG]) && !$rose(status_reg[S_BV]))
    else $error("autonomous fault flagged outside period");
  a_load_only: assert property (!rdTake |=> !$rose(status_reg[S_LOAD]))
    else $error("load-class fault flagged without a load");
  a_iptr_load: assert property (rdTake && s_axi_araddr == A_IPTR8 && iPoison_reg
                                |=> status_reg[S_PTR] && s_axi_rvalid)
    else $error("instruction pointer error missed");
  a_dptr_load: assert property (rdTake && s_axi_araddr == A_DPTRD && dPoison_reg |=> status_reg[S_PTR])
    else $error("data pointer error missed");
  a_pp_prop: assert property (parBad[3] |=> iPoison_reg && dPoison_reg)
    else $error("tag parity not propagated");
  a_itlb_chk: assert property (itlbUpdate && decUe[1] |=> status_reg[S_ITLB])
    else $error("instruction update fault missed");
  a_dtlb_chk: assert property (dtlbUpdate && decUe[2] |=> status_reg[S_DTLB])
    else $error("data update fault missed");
  a_tlb_use: assert property (!tlbLookup |=> !$rose(status_reg[S_TLBUSE]))
    else $error("lookup fault without lookup");
  a_enab_gate: assert property (!ctrl_reg[C_EN] |=> !$rose(status_reg[S_ENAB]))
    else $error("enable-class fault while disabled");
  a_bad_pkt: assert property (s_badPkt |=> s_trapNoBusy ##1 !vecTrap)
    else $error("bad packet handling wrong");
  a_ecc_fix: assert property (rdTake && s_axi_araddr == A_ECCREG && decCe[0]
                              |=> s_axi_rdata == $past(decFix[0]) && status_reg[S_CE])
    else $error("single flip not corrected");
endmodule : asec_reg_error_check

// file: pkg/asec_pkg.sv
package asec_pkg;
  // Data, check code and address widths; status type count
  localparam int DW  = 32;
  localparam int CW  = 7;
  localparam int AW  = 8;
  localparam int NST = 11;
  // Register byte addresses
  localparam logic [AW-1:0] A_CTRL   = 8'h00;
  localparam logic [AW-1:0] A_STATUS = 8'h04;
  localparam logic [AW-1:0] A_MASK   = 8'h08;
  localparam logic [AW-1:0] A_INJECT = 8'h0c;
  localparam logic [AW-1:0] A_ALWAYS = 8'h10;
  localparam logic [AW-1:0] A_AUG    = 8'h14;
  localparam logic [AW-1:0] A_ENREG  = 8'h18;
  localparam logic [AW-1:0] A_ECCREG = 8'h1c;
  localparam logic [AW-1:0] A_ISRC   = 8'h20;
  localparam logic [AW-1:0] A_DSRC   = 8'h24;
  localparam logic [AW-1:0] A_IPTR8  = 8'h28;
  localparam logic [AW-1:0] A_IPTR64 = 8'h2c;
  localparam logic [AW-1:0] A_DPTR8  = 8'h30;
  localparam logic [AW-1:0] A_DPTR64 = 8'h34;
  localparam logic [AW-1:0] A_DPTRD  = 8'h38;
  localparam logic [AW-1:0] A_RXDATA = 8'h3c;
  localparam logic [AW-1:0] A_RXBUSY = 8'h40;
  // Error control register fields
  localparam int C_UGH  = 0;
  localparam int C_WEAK = 1;
  localparam int C_EN   = 2;
  // Error status register fields
  localparam int S_ALWAYS = 0;
  localparam int S_AUG    = 1;
  localparam int S_BV     = 2;
  localparam int S_LOAD   = 3;
  localparam int S_PTR    = 4;
  localparam int S_ITLB   = 5;
  localparam int S_DTLB   = 6;
  localparam int S_TLBUSE = 7;
  localparam int S_ENAB   = 8;
  localparam int S_INTR   = 9;
  localparam int S_CE     = 10;
  // Inject register: parity flip bit above the check code flips
  localparam int I_PAR = 7;
  // Pointer field positions
  localparam int BASE_LSB = 12;
  localparam int PG8_LSB  = 13;
  localparam int PG64_LSB = 16;
  localparam int DIR_LSB  = 12;
  localparam logic [3:0] PTR_LOW8 = 4'h0;
  localparam logic [3:0] PTR_LOWD = 4'h8;
  // Reset values
  localparam logic [2:0]     RST_CTRL = 3'h0;
  localparam logic [NST-1:0] RST_MASK = 11'h000;
  // Bus responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // A data word with its check code
  typedef struct packed {
    logic [DW-1:0] data;
    logic [CW-1:0] check;
  } asec_code_t;
  // Write channel states
  typedef enum logic [1:0] {
    WS_COLLECT = 2'b01,
    WS_RESP    = 2'b10
  } asec_wr_t;
endpackage : asec_pkg

// file: rtl/asec_parity.sv
`timescale 1ns/1ps
module asec_parity import asec_pkg::*; (
  // Stored word
  input  wire logic [DW-1:0] data,
  input  wire logic          par,
  // Results
  output logic               gen,
  output logic               bad
);
  // Even parity: stored bit equals xor of data
  assign gen = ^data;
  assign bad = gen ^ par;
endmodule : asec_parity

// file: rtl/asec_secded.sv
`timescale 1ns/1ps
module asec_secded import asec_pkg::*; (
  // Stored word and its code
  input  asec_code_t          word,
  // Fresh code of the data, corrected data, flags
  output logic [CW-1:0]       genCheck,
  output logic [DW-1:0]       fixedData,
  output logic                corrErr,
  output logic                uncorrErr
);
  logic [5:0] hc;   // Hamming bits of the data
  logic [5:0] syn;  // Syndrome
  logic       ovr;  // Overall parity mismatch

  // Codeword position of data bit j: skips powers of two
  function automatic logic [5:0] dataPos(input int j);
    int         n;
    logic [5:0] p;
    logic [5:0] r;
    n = 0;
    r = '0;
    for (int k = 1; k < 64; k++) begin
      p = 6'(k);
      if ((p & (p - 6'h1)) != 6'h0) begin
        if (n == j) r = p;
        n++;
      end
    end
    return r;
  endfunction : dataPos

  // Encode, then decode against the stored code
  always_comb begin
    hc = '0;
    for (int j = 0; j < DW; j++) begin
      if (word.data[j]) hc = hc ^ dataPos(j);
    end
    genCheck  = {^{word.data, hc}, hc};
    syn       = hc ^ word.check[5:0];
    ovr       = ^{word.data, word.check};
    fixedData = word.data;
    // Odd overall parity means one flip, which is corrected
    for (int j = 0; j < DW; j++) begin
      if (ovr && syn == dataPos(j)) fixedData[j] = ~word.data[j];
    end
    corrErr   = ovr;
    // Even overall parity with a syndrome means two flips
    uncorrErr = !ovr && syn != 6'h0;
  end
endmodule : asec_secded

// file: tb/asec_link_model.sv
`timescale 1ns/1ps
module asec_link_model import asec_pkg::*; (
  // Clock
  input  wire logic core_clk,
  // Interrupt packets
  output logic       pktValid,
  output asec_code_t pkt,
  input  wire logic  pktReady,
  // Barrier link word
  output logic       bvValid,
  output asec_code_t bv
);
  // Hamming bits over positions 3,5,6,7,9.., top bit evens the whole word
  function automatic logic [CW-1:0] enc(input logic [DW-1:0] d);
    logic [CW-1:0] c;
    int            p;
    int            j;
    c = '0;
    j = 0;
    for (p = 3; j < DW; p++) if ((p & (p - 1)) != 0) begin
      c[5:0] ^= {6{d[j]}} & 6'(p);
      j++;
    end
    c[6] = ^{d, c[5:0]};
    return c;
  endfunction : enc
  // Idle at time zero
  initial begin
    pktValid = 1'b0;
    pkt      = '0;
    bvValid  = 1'b0;
    bv       = '0;
  end
  // Offer a packet after a gap and hold it until taken; f flips code bits
  task automatic send(input logic [DW-1:0] d, input logic [CW-1:0] f, input int gap);
    int n;
    repeat (gap + 1) @(posedge core_clk);
    pkt      <= {d, enc(d) ^ f};
    pktValid <= 1'b1;
    n = 0;
    do @(negedge core_clk); while (!pktReady && ++n < 40);
    @(posedge core_clk);
    pktValid <= 1'b0;
    // Released lines must not keep showing the last word
    pkt.data <= ~d;
  endtask : send
  // Barrier word, valid from now on
  task automatic setbv(input logic [DW-1:0] d, input logic [CW-1:0] f);
    @(posedge core_clk);
    bv      <= {d, enc(d) ^ f};
    bvValid <= 1'b1;
  endtask : setbv
endmodule : asec_link_model

// file: tb/asec_reg_error_check_tb.sv
`timescale 1ns/1ps
module asec_reg_error_check_tb import asec_pkg::*;;
  // Clock, reset, bus
  logic          core_clk, nrst;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DW-1:0] s_axi_wdata, s_axi_rdata, tagVa, rv;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rr;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // Pipeline events, far side, outputs
  logic [2:0]    evs;
  logic          itlbUpdate, dtlbUpdate, tlbLookup, tagWrite, tagVaPar;
  logic          pktValid, pktReady, bvValid, vecTrap, irq;
  asec_code_t    pkt, bv;
  int            fail_count, checks, i, j;
  assign {tlbLookup, dtlbUpdate, itlbUpdate} = evs;
  asec_reg_error_check dut_u (.*);
  asec_link_model link_u (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // Ready levels settle mid-cycle, so the value seen at negedge is the one at the next edge
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic ta, tw, tb;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 50; n++) begin
      @(negedge core_clk);
      {ta, tw, tb, rr} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    fail_count++;
    close_out();
  endtask : wr
  task automatic rd(input logic [AW-1:0] a);
    logic ta, tr;
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 50; n++) begin
      @(negedge core_clk);
      {ta, tr, rv, rr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    fail_count++;
    close_out();
  endtask : rd
  // Compare masked status, then clear it all
  task automatic sc(input logic [DW-1:0] m, input logic [DW-1:0] e, input string nm);
    rd(A_STATUS);
    chk(nm, e, rv & m);
    wr(A_STATUS, 32'h000007ff);
  endtask : sc
  initial begin
    nrst = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tagVa} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {evs, tagWrite, tagVaPar} = '0;
    {fail_count, checks} = '0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rd(A_CTRL);
    chk("ctrl", 32'h00000000, rv);
    rd(A_MASK);
    chk("mask", 32'h00000000, rv);
    rd(8'h44);
    chk("rresp", {30'h0, RESP_ERR}, {30'h0, rr});
    wr(8'h44, 32'h00000001);
    chk("bresp", {30'h0, RESP_ERR}, {30'h0, rr});
    $display("t1 done");
    // Parity fault in the always class re-sets after every clear
    wr(A_INJECT, 32'h00000080);
    wr(A_ALWAYS, 32'h00001234);
    wr(A_INJECT, 32'h00000000);
    @(negedge core_clk);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(A_MASK, 32'h000007ff);
    @(negedge core_clk);
    chk("irq on", 32'h1, {31'h0, irq});
    sc(32'h1, 32'h1, "always");
    sc(32'h1, 32'h1, "always");
    wr(A_ALWAYS, 32'h00001234);
    wr(A_STATUS, 32'h000007ff);
    sc(32'h7ff, 32'h0, "fixed");
    @(negedge core_clk);
    chk("irq clr", 32'h0, {31'h0, irq});
    $display("t2 done");
    wr(A_INJECT, 32'h00000080);
    wr(A_AUG, 32'h0000005a);
    wr(A_ENREG, 32'h000000a5);
    wr(A_INJECT, 32'h00000000);
    link_u.setbv(32'h00000077, 7'h03);
    for (i = 7; i >= 0; i--) begin
      wr(A_CTRL, DW'(i));
      wr(A_STATUS, 32'h000007ff);
      repeat (3) @(posedge core_clk);
      sc(32'h107, ((i & 3) == 0 ? 32'h6 : 32'h0) | (i[2] ? 32'h100 : 32'h0), "auto");
    end
    wr(A_AUG, 32'h0000005a);
    link_u.setbv(32'h00000077, 7'h00);
    wr(A_STATUS, 32'h000007ff);
    sc(32'h7ff, 32'h0, "auto fixed");
    $display("t3 done");
    for (i = 0; i < 2; i++) begin
      wr(A_INJECT, i ? 32'h3 : 32'h1);
      wr(A_ECCREG, 32'hcafe0001);
      wr(A_INJECT, 32'h00000000);
      sc(32'h7ff, 32'h0, "no load");
      rd(A_ECCREG);
      if (i == 0) chk("fixed data", 32'hcafe0001, rv);
      sc(32'h408, i ? 32'h8 : 32'h400, "load");
    end
    $display("t4 done");
    for (i = 0; i < 2; i++) begin
      wr(A_INJECT, i ? 32'h0 : 32'h3);
      wr(A_ISRC, 32'h12345000);
      wr(A_INJECT, i ? 32'h3 : 32'h0);
      wr(A_DSRC, 32'h6789a000);
      wr(A_INJECT, 32'h00000000);
      wr(A_STATUS, 32'h000007ff);
      for (j = 0; j < 3; j++) begin
        @(posedge core_clk) evs <= 3'(1 << j);
        @(posedge core_clk) evs <= 3'h0;
        sc(32'he0, (j == 2 || j == i) ? 32'(1 << (j + 5)) : 32'h0, "tlb event");
      end
      for (j = 0; j < 5; j++) begin
        rd(A_IPTR8 + AW'(4 * j));
        sc(32'h10, ((j < 2) == (i == 0)) ? 32'h10 : 32'h0, "pointer");
      end
    end
    wr(A_DSRC, 32'h6789a000);
    for (i = 1; i >= 0; i--) begin
      @(posedge core_clk);
      {tagWrite, tagVa, tagVaPar} <= {1'b1, 32'h00abc000, ^32'h00abc000 ^ i[0]};
      @(posedge core_clk) tagWrite <= 1'b0;
      wr(A_STATUS, 32'h000007ff);
      rd(A_DPTRD);
      sc(32'h10, i ? 32'h10 : 32'h0, "tag");
    end
    $display("t5 done");
    for (i = 0; i < 3; i++) begin
      link_u.send(32'hbeef0000 + DW'(i), i == 2 ? 7'h3 : 7'(i), i);
      @(negedge core_clk);
      chk("trap", 32'h1, {31'h0, vecTrap});
      chk("ready", 32'h0, {31'h0, pktReady});
      rd(A_RXBUSY);
      chk("busy", i == 2 ? 32'h0 : 32'h1, rv & 32'h1);
      rd(A_RXDATA);
      if (i < 2) chk("pkt data", 32'hbeef0000 + DW'(i), rv);
      sc(32'h200, i == 2 ? 32'h200 : 32'h0, "pkt ue");
      wr(A_RXBUSY, 32'h00000000);
      @(negedge core_clk);
      chk("reopen", 32'h1, {31'h0, pktReady});
    end
    $display("t6 done");
    close_out();
  end
endmodule : asec_reg_error_check_tb
